// *** hdl/ocs_osc_ctrl.sv ***
// Purpose: Oscillator control and status register with switch sequencing.
// Assumes: All pin inputs are asynchronous to mclk and pass two flip-flops.
// Notes:   Clock switching runs a request/acknowledge handshake with the clock mux.
`timescale 1ns/1ps
`include "ocs_cfg.svh"
module ocs_osc_ctrl #(
  parameter int unsigned ADDR_W        = 8,
  parameter int unsigned PLL_START_NS  = `OCS_PLL_START_NS,
  parameter int unsigned CLK_PERIOD_NS = `OCS_CLK_PERIOD_NS
) (
  input  logic              mclk,
  input  logic              rst,
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  input  ocs_pkg::ocs_src_t initialOscConfig,
  input  logic              monitorConfigBit,
  input  logic              onePinFreezeCfg,
  input  logic              clockFailDetect,
  input  logic              pllLockRaw,
  input  logic              sleepMode,
  input  logic              switchAck,
  output ocs_pkg::ocs_src_t currentSource,
  output ocs_pkg::ocs_src_t targetSource,
  output logic              oscSwitchReq,
  output logic              pllEnable,
  output logic              primaryOscRun,
  output logic              secondaryOscEnable,
  output logic              pinMapFreeze,
  output logic              irq
);
  import ocs_pkg::*;

  localparam int unsigned PLL_START_CYC =
    (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PLL_CNT_W = $clog2(PLL_START_CYC + 1);
  localparam int unsigned SYNC_W    = 9;

  if (PLL_START_CYC < 1 || CLK_PERIOD_NS < 1) begin : gBadTiming
    $error("ocs_osc_ctrl: PLL start-up time must be at least one cycle");
  end
  if (ADDR_W < 8 || ADDR_W > 32) begin : gBadAddr
    $error("ocs_osc_ctrl: ADDR_W must lie between 8 and 32");
  end

  logic              wrStb;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0]       wrData;
  logic [3:0]        wrStrb;
  logic              wrOk;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0]       rdData;
  logic              rdOk;

  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;
  logic              failSync;
  logic              lockSync;
  logic              sleepSync;
  logic              monitorSync;
  logic              oneWaySync;
  logic              ackSync;
  ocs_src_t          initSync;

  logic [1:0]        strapCnt_q;
  logic              strapDone;
  ocs_sw_state_t     state_q;
  ocs_src_t          nsrc_q;
  ocs_src_t          csrc_q;
  logic              osc_switch_enable_q;
  logic              clkFreeze_q;
  logic              pinFreeze_q;
  logic              sleepKeep_q;
  logic              secEn_q;
  logic              failFlag_q;
  logic              failPrev_q;
  logic              keyStage_q;
  logic              unlockArmed_q;
  logic [PLL_CNT_W-1:0] pllCnt_q;
  logic              lockPrev_q;
  logic [`OCS_EV_W-1:0] evStat_q;
  logic [`OCS_EV_W-1:0] evMask_q;

  logic              selFrozen;
  logic              pllMode;
  logic              lockStatus;
  logic              failRise;
  logic              ctrlWrLo;
  logic              ctrlWrHi;
  logic              keyWr;
  logic [`OCS_EV_W-1:0] events;
  logic [7:0]        ctrlLow;

  function automatic logic usesPll(input ocs_src_t src);
    usesPll = (src == `OCS_SRC_FRC_PLL) || (src == `OCS_SRC_PRI_PLL);
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr == ADDR_W'(`OCS_OFF_CTRL)) || (addr == ADDR_W'(`OCS_OFF_KEY)) ||
               (addr == ADDR_W'(`OCS_OFF_STAT)) || (addr == ADDR_W'(`OCS_OFF_MASK)) ||
               (addr == ADDR_W'(`OCS_OFF_INFO));
  endfunction

  ocs_axil_slave #(
    .ADDR_W (ADDR_W)
  ) uBus (
    .mclk          (mclk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrStb         (wrStb),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrOk          (wrOk),
    .rdAddr        (rdAddr),
    .rdData        (rdData),
    .rdOk          (rdOk)
  );

  // Two-flop synchronisers; only the second stage is ever read.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {initialOscConfig, switchAck, onePinFreezeCfg, monitorConfigBit,
                  sleepMode, pllLockRaw, clockFailDetect};
      syncB_q <= syncA_q;
    end
  end

  assign failSync    = syncB_q[0];
  assign lockSync    = syncB_q[1];
  assign sleepSync   = syncB_q[2];
  assign monitorSync = syncB_q[3];
  assign oneWaySync  = syncB_q[4];
  assign ackSync     = syncB_q[5];
  assign initSync    = syncB_q[8:6];

  assign wrOk     = isMapped(wrAddr);
  assign rdOk     = isMapped(rdAddr);
  assign ctrlWrLo = wrStb && (wrAddr == ADDR_W'(`OCS_OFF_CTRL)) && wrStrb[0];
  assign ctrlWrHi = wrStb && (wrAddr == ADDR_W'(`OCS_OFF_CTRL)) && wrStrb[1];
  assign keyWr    = wrStb && (wrAddr == ADDR_W'(`OCS_OFF_KEY));

  assign selFrozen = clkFreeze_q && monitorSync;
  assign strapDone = (strapCnt_q == `OCS_STRAP_WAIT);
  assign pllMode   = strapDone && usesPll(csrc_q) && (state_q == OCS_IDLE);
  assign lockStatus = pllMode &&
                      (lockSync || (pllCnt_q == PLL_CNT_W'(PLL_START_CYC)));
  assign failRise  = failSync && !failPrev_q && monitorSync;

  // Pins need two cycles to settle through the synchronisers before the strap is read.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strapCnt_q <= 2'h0;
    end else if (!strapDone) begin
      strapCnt_q <= strapCnt_q + 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= OCS_IDLE;
    end else begin
      case (state_q)
        OCS_IDLE: begin
          if (osc_switch_enable_q && strapDone) begin
            state_q <= OCS_REQ;
          end
        end
        OCS_REQ: begin
          if (ackSync) begin
            state_q <= OCS_DONE;
          end
        end
        OCS_DONE: begin
          if (!ackSync) begin
            state_q <= OCS_IDLE;
          end
        end
        default: state_q <= OCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_switch_enable_q <= 1'b0;
    end else if ((state_q == OCS_DONE) && !ackSync) begin
      osc_switch_enable_q <= 1'b0;
    end else if (ctrlWrLo && wrData[`OCS_BIT_SWITCH] && !selFrozen &&
                 (state_q == OCS_IDLE)) begin
      osc_switch_enable_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nsrc_q <= '0;
      csrc_q <= '0;
    end else if (strapCnt_q == (`OCS_STRAP_WAIT - 2'h1)) begin
      nsrc_q <= initSync;
      csrc_q <= initSync;
    end else begin
      if (ctrlWrHi && !selFrozen && !osc_switch_enable_q) begin
        nsrc_q <= wrData[`OCS_NSRC_LSB +: 3];
      end
      if ((state_q == OCS_REQ) && ackSync) begin
        csrc_q <= nsrc_q;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clkFreeze_q <= 1'b0;
      sleepKeep_q <= 1'b0;
      secEn_q     <= 1'b0;
    end else if (ctrlWrLo) begin
      clkFreeze_q <= wrData[`OCS_BIT_CLKFRZ];
      sleepKeep_q <= wrData[`OCS_BIT_SLEEPKEEP];
      secEn_q     <= wrData[`OCS_BIT_SECOND];
    end
  end

  // A first key then a second key arms one control write for the pin freeze bit.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keyStage_q    <= 1'b0;
      unlockArmed_q <= 1'b0;
    end else if (keyWr) begin
      keyStage_q    <= (wrData == `OCS_KEY_FIRST);
      unlockArmed_q <= keyStage_q && (wrData == `OCS_KEY_SECOND);
    end else if (ctrlWrLo) begin
      keyStage_q    <= 1'b0;
      unlockArmed_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinFreeze_q <= 1'b0;
    end else if (ctrlWrLo && unlockArmed_q) begin
      if (wrData[`OCS_BIT_PINFRZ] || !(oneWaySync && pinFreeze_q)) begin
        pinFreeze_q <= wrData[`OCS_BIT_PINFRZ];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      failPrev_q <= 1'b0;
      failFlag_q <= 1'b0;
    end else begin
      failPrev_q <= failSync;
      if (failRise) begin
        failFlag_q <= 1'b1;
      end else if (ctrlWrLo && !wrData[`OCS_BIT_FAIL]) begin
        failFlag_q <= 1'b0;
      end
    end
  end

  // The start-up timer restarts whenever the PLL leaves service.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pllCnt_q <= '0;
    end else if (!pllMode) begin
      pllCnt_q <= '0;
    end else if (pllCnt_q != PLL_CNT_W'(PLL_START_CYC)) begin
      pllCnt_q <= pllCnt_q + PLL_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lockPrev_q <= 1'b0;
    end else begin
      lockPrev_q <= lockStatus;
    end
  end

  always_comb begin
    events = '0;
    events[`OCS_EV_FAIL]   = failRise;
    events[`OCS_EV_SWDONE] = (state_q == OCS_DONE) && !ackSync;
    events[`OCS_EV_LOCK]   = lockStatus && !lockPrev_q;
  end

  // New events win over a write-one-to-clear in the same cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evStat_q <= '0;
    end else if (wrStb && (wrAddr == ADDR_W'(`OCS_OFF_STAT)) && wrStrb[0]) begin
      evStat_q <= (evStat_q & ~wrData[`OCS_EV_W-1:0]) | events;
    end else begin
      evStat_q <= evStat_q | events;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evMask_q <= '0;
    end else if (wrStb && (wrAddr == ADDR_W'(`OCS_OFF_MASK)) && wrStrb[0]) begin
      evMask_q <= wrData[`OCS_EV_W-1:0];
    end
  end

  always_comb begin
    ctrlLow = 8'h00;
    ctrlLow[`OCS_BIT_CLKFRZ]    = clkFreeze_q;
    ctrlLow[`OCS_BIT_PINFRZ]    = pinFreeze_q;
    ctrlLow[`OCS_BIT_PLLLOCK]   = lockStatus;
    ctrlLow[`OCS_BIT_UNUSED]    = 1'b0;
    ctrlLow[`OCS_BIT_FAIL]      = failFlag_q;
    ctrlLow[`OCS_BIT_SLEEPKEEP] = sleepKeep_q;
    ctrlLow[`OCS_BIT_SECOND]    = secEn_q;
    ctrlLow[`OCS_BIT_SWITCH]    = osc_switch_enable_q;
  end

  always_comb begin
    rdData = 32'h0;
    if (rdAddr == ADDR_W'(`OCS_OFF_CTRL)) begin
      rdData[7:0] = ctrlLow;
      rdData[`OCS_NSRC_LSB +: 3] = nsrc_q;
      rdData[`OCS_CSRC_LSB +: 3] = csrc_q;
    end else if (rdAddr == ADDR_W'(`OCS_OFF_STAT)) begin
      rdData[`OCS_EV_W-1:0] = evStat_q;
    end else if (rdAddr == ADDR_W'(`OCS_OFF_MASK)) begin
      rdData[`OCS_EV_W-1:0] = evMask_q;
    end else if (rdAddr == ADDR_W'(`OCS_OFF_INFO)) begin
      rdData[0] = monitorSync;
      rdData[1] = oneWaySync;
      rdData[2] = (state_q != OCS_IDLE);
      rdData[3] = selFrozen;
      rdData[4] = unlockArmed_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oscSwitchReq       <= 1'b0;
      pllEnable          <= 1'b0;
      primaryOscRun      <= 1'b1;
      secondaryOscEnable <= 1'b0;
      irq                <= 1'b0;
    end else begin
      oscSwitchReq       <= (state_q == OCS_IDLE) && osc_switch_enable_q && strapDone;
      if ((state_q == OCS_REQ) && ackSync) begin
        oscSwitchReq <= 1'b0;
      end else if (state_q == OCS_REQ) begin
        oscSwitchReq <= 1'b1;
      end
      pllEnable          <= strapDone && usesPll(csrc_q);
      primaryOscRun      <= !sleepSync || sleepKeep_q;
      secondaryOscEnable <= secEn_q;
      irq                <= |(evStat_q & evMask_q);
    end
  end

  assign currentSource = csrc_q;
  assign targetSource  = nsrc_q;
  assign pinMapFreeze  = pinFreeze_q;
endmodule // ocs_osc_ctrl

// *** hdl/ocs_cfg.svh ***
// Purpose: Constants of the oscillator control and status block.
// Assumes: 32-bit AXI4-Lite register bus, byte addresses below.
// Notes:   Types live in ocs_pkg; every offset, control and event field and timing constant lives here.
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH

`define OCS_OFF_CTRL      8'h00
`define OCS_OFF_KEY       8'h04
`define OCS_OFF_STAT      8'h08
`define OCS_OFF_MASK      8'h0c
`define OCS_OFF_INFO      8'h10

`define OCS_BIT_SWITCH    0
`define OCS_BIT_SECOND    1
`define OCS_BIT_SLEEPKEEP 2
`define OCS_BIT_FAIL      3
`define OCS_BIT_UNUSED    4
`define OCS_BIT_PLLLOCK   5
`define OCS_BIT_PINFRZ    6
`define OCS_BIT_CLKFRZ    7
`define OCS_NSRC_LSB      8
`define OCS_CSRC_LSB      12

`define OCS_EV_FAIL       0
`define OCS_EV_SWDONE     1
`define OCS_EV_LOCK       2
`define OCS_EV_W          3

`define OCS_KEY_FIRST     32'h0000_0046
`define OCS_KEY_SECOND    32'h0000_0057

`define OCS_SRC_FRC_PLL   3'h1
`define OCS_SRC_PRI_PLL   3'h3
`define OCS_PLL_MULT      4

`define OCS_PLL_START_NS  2000000
`define OCS_CLK_PERIOD_NS 10
`define OCS_STRAP_WAIT    2'h3

`define OCS_RESP_OKAY     2'h0
`define OCS_RESP_SLVERR   2'h2

`endif

// *** hdl/ocs_pkg.sv ***
// Purpose: Types of the oscillator control and status block.
// Assumes: Constants come from ocs_cfg.svh.
// Notes:   Switch state codes are one-hot.
package ocs_pkg;

  typedef logic [2:0] ocs_src_t;

  typedef enum logic [2:0] {
    OCS_IDLE = 3'b001,
    OCS_REQ  = 3'b010,
    OCS_DONE = 3'b100
  } ocs_sw_state_t;

endpackage

// *** hdl/ocs_axil_slave.sv ***
// Purpose: AXI4-Lite slave front end for the oscillator control block.
// Assumes: One write and one read outstanding at most.
// Notes:   Address and data are taken in either order; strobe fires once both held.
`timescale 1ns/1ps
`include "ocs_cfg.svh"
module ocs_axil_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input  logic              mclk,
  input  logic              rst,
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  output logic              wrStb,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [31:0]       wrData,
  output logic [3:0]        wrStrb,
  input  logic              wrOk,
  output logic [ADDR_W-1:0] rdAddr,
  input  logic [31:0]       rdData,
  input  logic              rdOk
);
  logic awHeld_q;
  logic wHeld_q;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign wrStb         = awHeld_q && wHeld_q;
  assign s_axi_arready = !s_axi_rvalid;
  assign rdAddr        = s_axi_araddr;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      wrAddr   <= '0;
      wrData   <= 32'h0;
      wrStrb   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        wrAddr   <= s_axi_awaddr;
      end else if (wrStb) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wrData  <= s_axi_wdata;
        wrStrb  <= s_axi_wstrb;
      end else if (wrStb) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OCS_RESP_OKAY;
    end else if (wrStb) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrOk ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `OCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdOk ? rdData : 32'h0;
      s_axi_rresp  <= rdOk ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ocs_axil_slave

// *** tb/ocs_osc_ctrl_monitor.sv ***
// Purpose: Port assertions for the oscillator control block.
// Assumes: Bound to ocs_osc_ctrl; read data is tied to a captured read address.
// Notes:   Straps stay stable from reset on.
`timescale 1ns/1ps
`include "ocs_cfg.svh"
module ocs_osc_ctrl_monitor #(
  parameter int unsigned ADDR_W = 8
) (
  input logic              mclk,
  input logic              rst,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [31:0]       s_axi_rdata,
  input logic [1:0]        s_axi_rresp,
  input logic              s_axi_rvalid,
  input ocs_pkg::ocs_src_t initialOscConfig,
  input logic              sleepMode,
  input logic              switchAck,
  input ocs_pkg::ocs_src_t currentSource,
  input ocs_pkg::ocs_src_t targetSource,
  input logic              oscSwitchReq,
  input logic              pllEnable,
  input logic              primaryOscRun,
  input logic              secondaryOscEnable,
  input logic              pinMapFreeze
);
  import ocs_pkg::*;
  logic [ADDR_W-1:0] rdAddr_q;
  logic              ctrlRd;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdAddr_q <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdAddr_q <= s_axi_araddr;
    end
  end
  assign ctrlRd = s_axi_rvalid && rdAddr_q == `OCS_OFF_CTRL && s_axi_rresp == `OCS_RESP_OKAY;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_unused_zero;
    ctrlRd |-> !s_axi_rdata[`OCS_BIT_UNUSED];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("bit four read as one");
  property p_second_en;
    ctrlRd |-> s_axi_rdata[`OCS_BIT_SECOND] == secondaryOscEnable;
  endproperty
  a_second_en: assert property (p_second_en) else $error("secondary enable mismatch");
  property p_pin_freeze;
    ctrlRd |-> s_axi_rdata[`OCS_BIT_PINFRZ] == pinMapFreeze;
  endproperty
  a_pin_freeze: assert property (p_pin_freeze) else $error("pin freeze mismatch");
  property p_lock_src;
    ctrlRd && s_axi_rdata[`OCS_BIT_PLLLOCK] |-> pllEnable && !oscSwitchReq;
  endproperty
  a_lock_src: assert property (p_lock_src) else $error("lock shown off PLL");
  property p_awake_run;
    !sleepMode [*5] |-> primaryOscRun;
  endproperty
  a_awake_run: assert property (p_awake_run) else $error("primary stopped awake");
  property p_switch_src;
    $fell(oscSwitchReq) |-> currentSource == targetSource;
  endproperty
  a_switch_src: assert property (p_switch_src) else $error("switch ended off target");
  property p_ack_end;
    $rose(switchAck) && oscSwitchReq |-> ##[1:5] !oscSwitchReq;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("request held after ack");
  property p_strap;
    $fell(rst) |-> ##3 currentSource == initialOscConfig && targetSource == initialOscConfig;
  endproperty
  a_strap: assert property (p_strap) else $error("sources not from strap");
endmodule // ocs_osc_ctrl_monitor
bind ocs_osc_ctrl ocs_osc_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .mclk(mclk), .rst(rst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .initialOscConfig(initialOscConfig), .sleepMode(sleepMode),
  .switchAck(switchAck), .currentSource(currentSource), .targetSource(targetSource),
  .oscSwitchReq(oscSwitchReq), .pllEnable(pllEnable), .primaryOscRun(primaryOscRun),
  .secondaryOscEnable(secondaryOscEnable), .pinMapFreeze(pinMapFreeze));

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the oscillator control block.
// Assumes: PLL start-up shortened to ten cycles.
// Notes:   Strap selects source 2, a non-PLL source.
`timescale 1ns/1ps
`include "ocs_cfg.svh"
module tb;
  import ocs_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] s;} ocs_row_t;
  logic        mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, monitorConfigBit, onePinFreezeCfg, clockFailDetect, pllLockRaw;
  logic        sleepMode, switchAck, oscSwitchReq, pllEnable, primaryOscRun, irq;
  logic        secondaryOscEnable, pinMapFreeze;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
  ocs_src_t    initialOscConfig, currentSource, targetSource;
  int          errors, n_checks;
  ocs_row_t    rows [6] = '{
    '{`OCS_OFF_CTRL, 32'h286, 32'h2286, 2'h0}, '{`OCS_OFF_CTRL, 32'h290, 32'h2280, 2'h0},
    '{`OCS_OFF_CTRL, 32'h200, 32'h2200, 2'h0}, '{`OCS_OFF_MASK, 32'hff, 32'h7, 2'h0},
    '{8'h14, 32'h1, 32'h0, `OCS_RESP_SLVERR}, '{`OCS_OFF_INFO, 32'hff, 32'h0, 2'h0}};
  ocs_osc_ctrl #(.PLL_START_NS(100)) dut (.*);
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic cr(input logic [7:0] a, input logic [31:0] m, e, input string n);
    rd(a);
    chk(n, v & m, e);
  endtask
  task automatic unlock();
    wr(`OCS_OFF_KEY, `OCS_KEY_FIRST);
    wr(`OCS_OFF_KEY, `OCS_KEY_SECOND);
  endtask
  // Runs one switch, acking the clock mux and checking state while it waits.
  task automatic sw(input logic [31:0] d);
    wr(`OCS_OFF_CTRL, d);
    @(posedge mclk iff oscSwitchReq);
    cr(`OCS_OFF_CTRL, 32'h21, 32'h1, "switch busy");
    switchAck <= 1'b1;
    @(posedge mclk iff !oscSwitchReq);
    switchAck <= 1'b0;
    do rd(`OCS_OFF_CTRL); while (v[0]);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #300us;
    errors++;
    end_sim();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, monitorConfigBit, onePinFreezeCfg} = '0;
    {clockFailDetect, pllLockRaw, sleepMode, switchAck} = '0;
    s_axi_wstrb = 4'hf;
    initialOscConfig = 3'h2;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    cr(`OCS_OFF_CTRL, 32'hffff_ffff, 32'h2200, "ctrl reset");
    chk("out reset", {pllEnable, primaryOscRun, irq, pinMapFreeze}, 4'b0100);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("row bresp", b, rows[i].s);
      rd(rows[i].a);
      chk("row data", v, rows[i].e);
      chk("row resp", r, rows[i].s);
    end
    wr(`OCS_OFF_CTRL, 32'h240);
    cr(`OCS_OFF_CTRL, 32'h40, 32'h0, "freeze no key");
    unlock();
    wr(`OCS_OFF_CTRL, 32'h240);
    cr(`OCS_OFF_CTRL, 32'h40, 32'h40, "freeze set");
    chk("freeze pin", pinMapFreeze, 1'b1);
    onePinFreezeCfg <= 1'b1;
    unlock();
    wr(`OCS_OFF_CTRL, 32'h200);
    cr(`OCS_OFF_CTRL, 32'h40, 32'h40, "one way");
    onePinFreezeCfg <= 1'b0;
    unlock();
    wr(`OCS_OFF_CTRL, 32'h200);
    cr(`OCS_OFF_CTRL, 32'h40, 32'h0, "freeze clear");
    sleepMode <= 1'b1;
    wr(`OCS_OFF_CTRL, 32'h204);
    repeat (4) @(posedge mclk);
    chk("sleep keep", primaryOscRun, 1'b1);
    wr(`OCS_OFF_CTRL, 32'h200);
    repeat (4) @(posedge mclk);
    chk("sleep stop", primaryOscRun, 1'b0);
    sleepMode <= 1'b0;
    sw(32'h101);
    chk("pll src", {currentSource, pllEnable}, 4'b0011);
    repeat (20) @(posedge mclk);
    cr(`OCS_OFF_CTRL, 32'h20, 32'h20, "lock");
    cr(`OCS_OFF_STAT, 32'h2, 32'h2, "done event");
    sw(32'h201);
    cr(`OCS_OFF_CTRL, 32'h20, 32'h0, "no pll lock");
    chk("plain src", {currentSource, pllEnable}, 4'b0100);
    monitorConfigBit <= 1'b1;
    wr(`OCS_OFF_CTRL, 32'h280);
    wr(`OCS_OFF_CTRL, 32'h381);
    cr(`OCS_OFF_CTRL, 32'h781, 32'h280, "frozen");
    chk("no req", oscSwitchReq, 1'b0);
    monitorConfigBit <= 1'b0;
    sw(32'h381);
    chk("unfrozen src", currentSource, 3'h3);
    monitorConfigBit <= 1'b1;
    wr(`OCS_OFF_STAT, 32'h7);
    wr(`OCS_OFF_MASK, 32'h1);
    clockFailDetect <= 1'b1;
    repeat (4) @(posedge mclk);
    clockFailDetect <= 1'b0;
    cr(`OCS_OFF_CTRL, 32'h8, 32'h8, "fail flag");
    chk("irq on", irq, 1'b1);
    wr(`OCS_OFF_CTRL, 32'h388);
    cr(`OCS_OFF_CTRL, 32'h8, 32'h8, "fail kept");
    wr(`OCS_OFF_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq masked", irq, 1'b0);
    wr(`OCS_OFF_CTRL, 32'h380);
    cr(`OCS_OFF_CTRL, 32'h8, 32'h0, "fail clear");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    cr(`OCS_OFF_CTRL, 32'hffff_ffff, 32'h2200, "ctrl rereset");
    chk("pin rereset", pinMapFreeze, 1'b0);
    end_sim();
  end
endmodule // tb
